// file: hw/nfh_core.sv
// numeric format handling datapath: float classify/flush/pack, fixed multiply, lanes
// Functional notes
// - single float word is one sign, 8-bit biased exponent, 24-bit significand
// - normal single stores 23-bit fraction behind an implicit leading one
// - normal exponents run 1 to 254; true exponent is field minus 127
// - exponent 255 with nonzero fraction is not-a-number
// - exponent 255 with zero fraction is signed infinity
// - exponent zero with zero fraction is signed zero
// - no inexact flag is ever produced
// - any NaN input raises invalid and returns a quiet NaN
// - NaN result sign is XOR of the two input signs
// - denormal inputs become zero without an underflow flag
// - denormal or underflowing results become zero and raise underflow
// - only round to nearest and round toward zero exist
// - extended is 40 bits: same exponent, 32-bit significand, same special rules
// - extended pair leaves bit 63 and bits 54..32 unused
// - fixed point 16/32/64 frac or int, signed or unsigned; 8-bit signed int
// - fractional point left of top magnitude bit, integer point right of LSB
// - two's complement sign bit carries negative weight
// - lanes: single 4x8/2x16, double 8x8/4x16, quad 16x8/8x16
// - ALU results keep the width and format of their inputs
// - multiply 32x32 gives 32 or 64 bits, 16x16 gives 16 or 32 bits
// - product signed if any operand signed, unsigned only if both unsigned
// - signed fractional product shifts left one, bit 62 to sign, LSB zero
`timescale 1ns/1ps
module nfh_core (
    input  wire logic             clk_i,     // core clock
    input  wire logic             rst_n_i,   // async reset, active low
    input  wire logic             req_vld_i, // request strobe
    input  wire nfh_pkg::nfh_req_t req_i,    // request fields
    output logic                  vld_o,     // result strobe
    output logic [63:0]           res_o,     // result word
    output nfh_pkg::nfh_cls_t     cls_o,     // class of operand a, or of the packed result for a pack
    output nfh_pkg::nfh_flg_t     flg_o,     // exception flags
    output logic                  res_ext_o  // result is extended format
);
    import nfh_pkg::*;

    // split a register word into fields; extended fraction already 31 bits
    function automatic nfh_fp_t unpack(input logic [63:0] w, input logic ext);
        nfh_fp_t f;
        if (ext) begin
            f.sgn = w[EXT_SGN_BIT];
            f.exp = w[EXT_EXP_LSB +: EXP_W];
            f.frc = w[FRC_W-1:0];
        end else begin
            f.sgn = w[SGL_SGN_BIT];
            f.exp = w[SGL_EXP_LSB +: EXP_W];
            f.frc = {w[SGL_FRC_W-1:0], 8'h00};
        end
        return f;
    endfunction

    // rebuild a register word; unused extended bits stay zero
    function automatic logic [63:0] pack(input nfh_fp_t f, input logic ext);
        logic [63:0] w;
        w = RES_RST;
        if (ext) begin
            w[EXT_SGN_BIT]          = f.sgn;
            w[EXT_EXP_LSB +: EXP_W] = f.exp;
            w[FRC_W-1:0]            = f.frc;
        end else begin
            w[SGL_SGN_BIT]          = f.sgn;
            w[SGL_EXP_LSB +: EXP_W] = f.exp;
            w[SGL_FRC_W-1:0]        = f.frc[FRC_W-1 -: SGL_FRC_W];
        end
        return w;
    endfunction

    // one classifier serves both widths, so special values match
    function automatic nfh_cls_t classify(input nfh_fp_t f);
        nfh_cls_t c;
        if (f.exp == EXP_ALL1) begin
            c = (f.frc != '0) ? CLS_NAN : CLS_INF;
        end else if (f.exp == EXP_ZERO) begin
            c = (f.frc != '0) ? CLS_DENORM : CLS_ZERO;
        end else begin
            c = CLS_NORMAL;
        end
        return c;
    endfunction

    // 32x32 multiply, each operand signed or unsigned on its own
    function automatic logic [63:0] mul32(input logic [31:0] x, input logic [31:0] y,
                                          input logic xs, input logic ys);
        logic signed [32:0] ex;
        logic signed [32:0] ey;
        logic signed [65:0] p;
        ex = $signed({xs & x[31], x});
        ey = $signed({ys & y[31], y});
        p  = ex * ey;
        return p[63:0];
    endfunction

    // operand decode
    nfh_fp_t     fa;
    nfh_fp_t     fb;
    nfh_cls_t    ca;
    nfh_cls_t    cb;
    nfh_fp_t     fz;
    assign fa = unpack(req_i.a, req_i.ext);
    assign fb = unpack(req_i.b, req_i.ext);
    assign ca = classify(fa);
    assign cb = classify(fb);
    // flushed copy of a: denormal becomes signed zero, no flag raised
    assign fz = (ca == CLS_DENORM) ? nfh_fp_t'{sgn: fa.sgn, exp: EXP_ZERO, frc: '0}
                                   : fa;

    // pack path: round then flush or overflow to infinity
    logic [9:0]  pk_exp;
    logic [31:0] pk_sig;
    logic [10:0] pk_be;
    logic [10:0] pk_be2;
    logic [32:0] pk_keep;
    logic [32:0] pk_rnd;
    logic        pk_grd;
    logic        pk_stk;
    logic        pk_inc;
    logic        pk_cry;
    nfh_fp_t     pk_f;
    logic        pk_unf;
    logic        pk_ovf;

    always_comb begin
        pk_exp  = req_i.a[DEC_EXP_LSB +: DEC_EXP_W];
        pk_sig  = req_i.a[31:0];
        pk_be   = {pk_exp[9], pk_exp} + EXP_BIAS;
        if (req_i.ext) begin
            pk_keep = {1'b0, pk_sig};
            pk_grd  = req_i.b[7];
            pk_stk  = |req_i.b[6:0];
        end else begin
            pk_keep = {9'h000, pk_sig[31:8]};
            pk_grd  = pk_sig[7];
            pk_stk  = (|pk_sig[6:0]) | (|req_i.b[7:0]);
        end
        // nearest ties to even; toward zero just truncates
        pk_inc  = (req_i.rnd == RND_NEAREST) & pk_grd & (pk_stk | pk_keep[0]);
        pk_rnd  = pk_keep + {32'h0, pk_inc};
        pk_cry  = req_i.ext ? pk_rnd[32] : pk_rnd[24];
        pk_be2  = pk_be + {10'h000, pk_cry};
        pk_f.sgn = req_i.a[DEC_SGN_BIT];
        pk_f.exp = pk_be2[7:0];
        if (pk_cry) begin
            pk_f.frc = '0;                              // 1.11..1 rounded up to 10.0
        end else if (req_i.ext) begin
            pk_f.frc = pk_rnd[FRC_W-1:0];
        end else begin
            pk_f.frc = {pk_rnd[SGL_FRC_W-1:0], 8'h00};
        end
        pk_unf = 1'b0;
        pk_ovf = 1'b0;
        if (pk_sig == 32'h0) begin
            pk_f.exp = EXP_ZERO;
            pk_f.frc = '0;
        end else if ($signed(pk_be) < $signed(11'h001)) begin
            // tiny results never become denormals
            pk_f.exp = EXP_ZERO;
            pk_f.frc = '0;
            pk_unf   = 1'b1;
        end else if ($signed(pk_be2) > $signed(EXP_MAXN)) begin
            pk_f.exp = EXP_ALL1;
            pk_f.frc = '0;
            pk_ovf   = 1'b1;
        end
    end

    // fixed-point multiply
    logic [63:0] mu_res;
    logic [63:0] mu_p;
    logic [31:0] mu_q;
    logic        mu_shf;

    always_comb begin
        // only signed fractions carry a redundant sign bit to drop
        mu_shf = req_i.frac & req_i.a_sgn & req_i.b_sgn;
        mu_res = RES_RST;
        mu_p   = RES_RST;
        mu_q   = 32'h0;
        if (!req_i.mul16) begin
            mu_p = mul32(req_i.a[31:0], req_i.b[31:0], req_i.a_sgn, req_i.b_sgn);
            if (mu_shf) begin
                mu_p = {mu_p[62:0], 1'b0};
            end
            if (req_i.wide) begin
                mu_res = mu_p;
            end else begin
                mu_res = {32'h0, req_i.frac ? mu_p[63:32] : mu_p[31:0]};
            end
        end else begin
            // two 16-bit lanes of a single register
            for (int i = 0; i < 2; i++) begin
                mu_p = mul32({{16{req_i.a_sgn & req_i.a[16*i+15]}}, req_i.a[16*i +: 16]},
                             {{16{req_i.b_sgn & req_i.b[16*i+15]}}, req_i.b[16*i +: 16]},
                             req_i.a_sgn, req_i.b_sgn);
                mu_q = mu_p[31:0];                      // a 16x16 product fits the low word
                if (mu_shf) begin
                    mu_q = {mu_q[30:0], 1'b0};
                end
                if (req_i.wide) begin
                    mu_res[32*i +: 32] = mu_q;
                end else begin
                    mu_res[16*i +: 16] = req_i.frac ? mu_q[31:16] : mu_q[15:0];
                end
            end
        end
    end

    // lane extract from a quad {b,a}
    logic [127:0] ln_quad;
    logic [4:0]   ln_cnt;
    logic [15:0]  ln_el;
    logic         ln_sgn;
    logic         ln_frac;
    logic [63:0]  ln_res;
    logic         ln_rng;

    always_comb begin
        ln_quad = {req_i.b, req_i.a};
        unique case (req_i.lrw)
            RW_SINGLE: ln_cnt = LANES_SGL;
            RW_DOUBLE: ln_cnt = LANES_DBL;
            RW_QUAD:   ln_cnt = LANES_QUAD;
            default:   ln_cnt = 5'h00;                  // unused code has no lanes
        endcase
        if (req_i.lsz == LSZ_SHORT) begin
            ln_cnt = ln_cnt >> 1;
        end
        ln_rng = ({1'b0, req_i.lidx} >= ln_cnt);
        ln_el  = 16'h0;
        ln_res = RES_RST;
        if (req_i.lsz == LSZ_SHORT) begin
            ln_el   = ln_quad[{req_i.lidx[2:0], 4'h0} +: 16];
            ln_sgn  = req_i.a_sgn;
            ln_frac = req_i.frac;
        end else begin
            // bytes only exist as signed integers
            ln_el   = {ln_quad[{req_i.lidx, 3'h0} +: 8], 8'h00};
            ln_sgn  = 1'b1;
            ln_frac = 1'b0;
        end
        if (ln_rng) begin
            ln_res = RES_RST;
        end else if (ln_frac) begin
            // left aligned: binary point just under the top bit
            ln_res = {ln_el, 48'h0};
        end else if (req_i.lsz == LSZ_SHORT) begin
            ln_res = {{48{ln_sgn & ln_el[15]}}, ln_el};
        end else begin
            ln_res = {{56{ln_el[15]}}, ln_el[15:8]};
        end
    end

    // result select
    logic        vld_d;
    logic        vld_q;
    logic [63:0] res_d;
    logic [63:0] res_q;
    nfh_cls_t    cls_d;
    nfh_cls_t    cls_q;
    nfh_flg_t    flg_d;
    nfh_flg_t    flg_q;
    logic        ext_d;
    logic        ext_q;
    nfh_fp_t     qn;

    always_comb begin
        vld_d = req_vld_i;
        cls_d = ca;
        ext_d = req_i.ext;
        res_d = RES_RST;
        flg_d = '0;
        // quiet NaN: all-ones exponent, top fraction bit set
        qn.sgn = fa.sgn ^ fb.sgn;
        qn.exp = EXP_ALL1;
        qn.frc = {1'b1, 30'h0};
        unique case (req_i.op)
            OP_DECODE: begin
                res_d[DEC_SGN_BIT] = fz.sgn;
                res_d[DEC_EXP_LSB +: DEC_EXP_W] = 10'({2'b00, fz.exp} - EXP_BIAS);
                res_d[31:0] = {(ca == CLS_NORMAL), fz.frc};
            end
            OP_NANCHK: begin
                if ((ca == CLS_NAN) || (cb == CLS_NAN)) begin
                    res_d = pack(qn, req_i.ext);
                    flg_d.invalid = 1'b1;
                end else begin
                    res_d = pack(fz, req_i.ext);
                end
            end
            OP_PACK: begin
                res_d = pack(pk_f, req_i.ext);
                flg_d.underflow = pk_unf;
                flg_d.overflow  = pk_ovf;
                cls_d = classify(pk_f);
            end
            OP_FMUL: begin
                res_d = mu_res;
                ext_d = 1'b0;
            end
            OP_LANE: begin
                res_d = ln_res;
                flg_d.range = ln_rng;
                ext_d = 1'b0;
            end
            default: begin
                flg_d.invalid = req_vld_i;              // unknown op code
            end
        endcase
        if (!req_vld_i) begin
            res_d = res_q;
            cls_d = cls_q;
            flg_d = flg_q;
            ext_d = ext_q;
        end
    end

    // output registers; results hold until the next request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vld_q <= 1'b0;
            res_q <= RES_RST;
            cls_q <= CLS_ZERO;
            flg_q <= '0;
            ext_q <= 1'b0;
        end else begin
            vld_q <= vld_d;
            res_q <= res_d;
            cls_q <= cls_d;
            flg_q <= flg_d;
            ext_q <= ext_d;
        end
    end

    assign vld_o     = vld_q;
    assign res_o     = res_q;
    assign cls_o     = cls_q;
    assign flg_o     = flg_q;
    assign res_ext_o = ext_q;
endmodule

// file: hw/nfh_pkg.sv
// numeric format handling: constants, encodings and carrier types
package nfh_pkg;
    // floating-point field layout
    localparam int unsigned EXP_W       = 8;
    localparam int unsigned FRC_W       = 31;
    localparam int unsigned SGL_FRC_W   = 23;
    localparam int unsigned SGL_SGN_BIT = 31;
    localparam int unsigned SGL_EXP_LSB = 23;
    localparam int unsigned EXT_SGN_BIT = 31;
    localparam int unsigned EXT_EXP_LSB = 55;
    localparam int unsigned EXT_PAD_W   = 8;
    localparam logic [7:0]  EXP_ZERO    = 8'h00;
    localparam logic [7:0]  EXP_ALL1    = 8'hff;
    localparam logic [10:0] EXP_BIAS    = 11'h07f;
    localparam logic [10:0] EXP_MAXN    = 11'h0fe;
    // decoded / packable layout: sign, true exponent, significand
    localparam int unsigned DEC_SGN_BIT = 63;
    localparam int unsigned DEC_EXP_LSB = 32;
    localparam int unsigned DEC_EXP_W   = 10;
    // lane counts per register for byte lanes
    localparam logic [4:0]  LANES_SGL   = 5'h04;
    localparam logic [4:0]  LANES_DBL   = 5'h08;
    localparam logic [4:0]  LANES_QUAD  = 5'h10;
    // reset values
    localparam logic [63:0] RES_RST     = 64'h0;

    typedef enum logic [2:0] {
        OP_DECODE = 3'b000,
        OP_NANCHK = 3'b001,
        OP_PACK   = 3'b010,
        OP_FMUL   = 3'b011,
        OP_LANE   = 3'b100
    } nfh_op_t;

    typedef enum logic [2:0] {
        CLS_ZERO   = 3'b000,
        CLS_DENORM = 3'b001,
        CLS_NORMAL = 3'b010,
        CLS_INF    = 3'b011,
        CLS_NAN    = 3'b100
    } nfh_cls_t;

    typedef enum logic {RND_NEAREST = 1'b0, RND_ZERO = 1'b1} nfh_rnd_t;
    typedef enum logic {LSZ_BYTE = 1'b0, LSZ_SHORT = 1'b1} nfh_lsz_t;
    typedef enum logic [1:0] {RW_SINGLE = 2'b00, RW_DOUBLE = 2'b01, RW_QUAD = 2'b10} nfh_rw_t;

    typedef struct packed {
        nfh_op_t     op;
        logic        ext;
        nfh_rnd_t    rnd;
        logic [63:0] a;
        logic [63:0] b;
        logic        a_sgn;
        logic        b_sgn;
        logic        frac;
        logic        wide;
        logic        mul16;
        nfh_lsz_t    lsz;
        nfh_rw_t     lrw;
        logic [3:0]  lidx;
    } nfh_req_t;

    typedef struct packed {
        logic invalid;
        logic underflow;
        logic overflow;
        logic range;
    } nfh_flg_t;

    typedef struct packed {
        logic       sgn;
        logic [7:0] exp;
        logic [30:0] frc;
    } nfh_fp_t;
endpackage

// file: tb/nfh_core_assertions.sv
// port-level checks for the numeric format datapath
`timescale 1ns/1ps
module nfh_core_assertions (
    input wire logic              clk_i,     // clock
    input wire logic              rst_n_i,   // reset
    input wire logic              req_vld_i, // strobe
    input wire nfh_pkg::nfh_req_t req_i,     // request
    input wire logic              vld_o,     // result strobe
    input wire logic [63:0]       res_o,     // result
    input wire nfh_pkg::nfh_cls_t cls_o,     // class
    input wire nfh_pkg::nfh_flg_t flg_o,     // flags
    input wire logic              res_ext_o  // extended
);
    import nfh_pkg::*;
    logic        sg;
    logic        an;
    logic        bn;
    logic        ad;
    logic        sa;
    logic        sx;
    logic [9:0]  te;
    logic [63:0] ps;
    logic [63:0] pu;
    // single-layout operand decode; extended layout is left to the bench
    assign sg = req_vld_i && !req_i.ext;
    assign an = req_i.a[30:23] == EXP_ALL1 && req_i.a[22:0] != 23'h0;
    assign bn = req_i.b[30:23] == EXP_ALL1 && req_i.b[22:0] != 23'h0;
    assign ad = req_i.a[30:23] == EXP_ZERO && req_i.a[22:0] != 23'h0;
    assign sa = req_i.a[31];
    assign sx = req_i.a[31] ^ req_i.b[31];
    assign te = {2'h0, req_i.a[30:23]} - 10'h07f;
    // expected products; the signed one already carries the renormalising shift
    assign ps = ($signed(req_i.a[31:0]) * $signed(req_i.b[31:0])) <<< 1;
    assign pu = {32'h0, req_i.a[31:0]} * {32'h0, req_i.b[31:0]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_inf; sg && req_i.op == OP_DECODE && req_i.a[30:0] == 31'h7f800000
        |=> cls_o == CLS_INF && res_o[63] == $past(sa); endproperty
    a_inf: assert property (p_inf) else $error("infinity misclassed");
    property p_zro; sg && req_i.op == OP_DECODE && req_i.a[30:0] == 31'h0
        |=> cls_o == CLS_ZERO && res_o[63] == $past(sa); endproperty
    a_zro: assert property (p_zro) else $error("zero misclassed");
    property p_exp; sg && req_i.op == OP_DECODE && !an && !ad && req_i.a[30:23] != 8'hff
        && req_i.a[30:23] != 8'h00 |=> res_o[41:32] == $past(te) && res_o[31]; endproperty
    a_exp: assert property (p_exp) else $error("true exponent wrong");
    property p_nq; sg && req_i.op == OP_NANCHK && (an || bn)
        |=> flg_o.invalid && res_o[30:22] == 9'h1ff; endproperty
    a_nq: assert property (p_nq) else $error("no quiet nan");
    property p_ns; sg && req_i.op == OP_NANCHK && (an || bn) |=> res_o[31] == $past(sx); endproperty
    a_ns: assert property (p_ns) else $error("nan sign wrong");
    property p_den; sg && req_i.op == OP_NANCHK && ad && !bn
        |=> res_o[30:0] == 31'h0 && !flg_o.underflow; endproperty
    a_den: assert property (p_den) else $error("denormal not flushed");
    property p_pad; req_vld_i && req_i.ext && req_i.op == OP_NANCHK
        |=> res_ext_o && !res_o[63] && res_o[54:32] == 23'h0; endproperty
    a_pad: assert property (p_pad) else $error("unused pair bits set");
    property p_sfr; req_vld_i && req_i.op == OP_FMUL && req_i.wide && req_i.frac
        && req_i.a_sgn && req_i.b_sgn && !req_i.mul16 |=> res_o == $past(ps); endproperty
    a_sfr: assert property (p_sfr) else $error("signed fraction product wrong");
    property p_uns; req_vld_i && req_i.op == OP_FMUL && req_i.wide && !req_i.frac
        && !req_i.a_sgn && !req_i.b_sgn && !req_i.mul16 |=> res_o == $past(pu); endproperty
    a_uns: assert property (p_uns) else $error("unsigned product wrong");
    property p_rng; req_vld_i && req_i.op == OP_LANE && req_i.lsz == LSZ_SHORT
        && req_i.lrw == RW_SINGLE && req_i.lidx > 4'h1 |=> flg_o.range && res_o == 64'h0; endproperty
    a_rng: assert property (p_rng) else $error("lane beyond count taken");
endmodule

bind nfh_core nfh_core_assertions nfh_core_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_vld_i(req_vld_i), .req_i(req_i), .vld_o(vld_o), .res_o(res_o), .cls_o(cls_o),
    .flg_o(flg_o), .res_ext_o(res_ext_o));

// file: tb/nfh_rf_model.sv
// register file stand-in: takes each returned result as a write-back
`timescale 1ns/1ps
module nfh_rf_model (
    input  wire logic        clk_i,    // clock
    input  wire logic        rst_n_i,  // reset, active low
    input  wire logic        wb_vld_i, // write-back strobe
    input  wire logic [63:0] wb_dat_i, // write-back data
    output logic [63:0]      reg_o     // destination register
);
    // only the strobe writes, so a result left standing is not taken again
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_o <= 64'h0;
        end else if (wb_vld_i) begin
            reg_o <= wb_dat_i;
        end
    end
endmodule

// file: tb/nfh_core_bench.sv
// self-checking bench for the numeric format datapath
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module nfh_core_bench;
    import nfh_pkg::*;
    localparam logic [13:0] EX = 14'h2000, RZ = 14'h1000, AS = 14'h0800, SI = 14'h0c00;
    localparam logic [13:0] SF = 14'h0e00, FR = 14'h0200, WD = 14'h0100, MS = 14'h0080;
    localparam logic [13:0] SH = 14'h0040, DB = 14'h0010, QD = 14'h0020;
    localparam logic [63:0] M_A = 64'hffffffffffffffff, M_L = 64'hffffffff;
    localparam logic [63:0] M_D = 64'h800003ffffffffff, M_S = 64'h8000000000000000;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_vld_i = 1'b0;
    nfh_req_t    req_i = '0;
    logic        vld_o;
    logic [63:0] res_o;
    nfh_cls_t    cls_o;
    nfh_flg_t    flg_o;
    logic        res_ext_o;
    logic [63:0] rf_reg;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;

    nfh_core nfh_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_vld_i(req_vld_i), .req_i(req_i),
        .vld_o(vld_o), .res_o(res_o), .cls_o(cls_o), .flg_o(flg_o), .res_ext_o(res_ext_o));
    nfh_rf_model nfh_rf_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_vld_i(vld_o),
        .wb_dat_i(res_o), .reg_o(rf_reg));

    // 20 MHz core clock
    always #25 clk_i = ~clk_i;

    // hang guard, far above the hundred-odd cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one request held through its taking edge; result judged while it stands
    task automatic chk(input nfh_op_t op, input logic [63:0] a, b, input logic [13:0] c,
                       input logic [63:0] e, m, input logic [3:0] f);
        @(posedge clk_i);
        #1;
        req_vld_i = 1'b1;
        req_i = '{op, c[13], nfh_rnd_t'(c[12]), a, b, c[11], c[10], c[9], c[8], c[7],
                  nfh_lsz_t'(c[6]), nfh_rw_t'(c[5:4]), c[3:0]};
        @(posedge clk_i);
        #1;
        req_vld_i = 1'b0;
        `CHK(vld_o, 1'b1)
        `CHK(res_o & m, e)
        `CHK(res_ext_o, c[13] && op != OP_FMUL && op != OP_LANE)
        if (op != OP_DECODE) `CHK(flg_o, f)
        @(posedge clk_i);
        #1;
        `CHK(vld_o, 1'b0)
        `CHK(rf_reg & m, e)
    endtask

    task automatic t_class();
        logic [31:0] v [7] = '{32'h0, 32'h80000000, 32'h80000001, 32'h3f800000,
                               32'h7f800000, 32'hff800000, 32'h7fc00001};
        nfh_cls_t    k [7] = '{CLS_ZERO, CLS_ZERO, CLS_DENORM, CLS_NORMAL,
                               CLS_INF, CLS_INF, CLS_NAN};
        for (int i = 0; i < 7; i++) begin
            chk(OP_DECODE, {32'h0, v[i]}, 64'h0, 14'h0, {v[i][31], 63'h0}, M_S, 4'h0);
            `CHK(cls_o, k[i])
        end
        chk(OP_DECODE, 64'hc0200000, 64'h0, 14'h0, 64'h80000001a0000000, M_D, 4'h0);
        chk(OP_DECODE, 64'h00800000, 64'h0, 14'h0, 64'h0000038280000000, M_D, 4'h0);
        chk(OP_DECODE, 64'h7f000000, 64'h0, 14'h0, 64'h0000007f80000000, M_D, 4'h0);
        chk(OP_DECODE, 64'h4000000080000001, 64'h0, EX, 64'h8000000180000001, M_D, 4'h0);
        $display("test class done");
    endtask

    task automatic t_nan();
        chk(OP_NANCHK, 64'hffc00001, 64'h3f800000, 14'h0, 64'hffc00000, M_L, 4'h8);
        chk(OP_NANCHK, 64'hff800001, 64'hffffffff, 14'h0, 64'h7fc00000, M_L, 4'h8);
        chk(OP_NANCHK, 64'hff800000, 64'h7f800001, 14'h0, 64'hffc00000, M_L, 4'h8);
        chk(OP_NANCHK, 64'h80000005, 64'h0, 14'h0, 64'h80000000, M_L, 4'h0);
        chk(OP_NANCHK, 64'hc87fffff00000001, 64'h0, EX, 64'h4800000000000001, M_A, 4'h0);
        chk(OP_NANCHK, 64'h7f80000000000001, 64'h0, EX, 64'h7f80000040000000, M_A, 4'h8);
        chk(nfh_op_t'(3'h5), 64'h3f800000, 64'h0, 14'h0, 64'h0, M_A, 4'h8);
        $display("test nan done");
    endtask

    task automatic t_pack();
        chk(OP_PACK, 64'h80000180, 64'h0, 14'h0, 64'h3f800002, M_L, 4'h0);
        chk(OP_PACK, 64'h80000180, 64'h0, RZ, 64'h3f800001, M_L, 4'h0);
        chk(OP_PACK, 64'h80000080, 64'h0, 14'h0, 64'h3f800000, M_L, 4'h0);
        chk(OP_PACK, 64'h8000038180000000, 64'h0, 14'h0, 64'h80000000, M_L, 4'h4);
        chk(OP_PACK, 64'h0000008080000000, 64'h0, 14'h0, 64'h7f800000, M_L, 4'h2);
        $display("test pack done");
    endtask

    task automatic t_fmul();
        chk(OP_FMUL, 64'h40000000, 64'h40000000, SF | WD, 64'h2000000000000000, M_A, 4'h0);
        chk(OP_FMUL, 64'h80000000, 64'h80000000, SF | WD, 64'h8000000000000000, M_A, 4'h0);
        chk(OP_FMUL, 64'h40000000, 64'h40000000, SF, 64'h20000000, M_A, 4'h0);
        chk(OP_FMUL, 64'h40000000, 64'h40000000, FR | WD, 64'h1000000000000000, M_A, 4'h0);
        chk(OP_FMUL, 64'hffffffff, 64'h2, WD, 64'h1fffffffe, M_A, 4'h0);
        chk(OP_FMUL, 64'hffffffff, 64'h2, AS | WD, 64'hfffffffffffffffe, M_A, 4'h0);
        chk(OP_FMUL, 64'hffffffff, 64'h2, AS, 64'hfffffffe, M_A, 4'h0);
        chk(OP_FMUL, 64'h0003fffe, 64'h00020004, SI | WD | MS, 64'h6fffffff8, M_A, 4'h0);
        chk(OP_FMUL, 64'h0003fffe, 64'h00020004, SI | MS, 64'h0006fff8, M_L, 4'h0);
        $display("test multiply done");
    endtask

    task automatic t_lane();
        chk(OP_LANE, 64'h807f01fe, 64'h0, 14'h3, 64'hffffffffffffff80, M_A, 4'h0);
        chk(OP_LANE, 64'h807f01fe, 64'h0, 14'h2, 64'h7f, M_A, 4'h0);
        chk(OP_LANE, 64'h0, 64'h9a00000000000000, QD | 14'hf, 64'hffffffffffffff9a, M_A, 4'h0);
        chk(OP_LANE, 64'h80001234, 64'h0, SH | FR | 14'h1, M_S, M_A, 4'h0);
        chk(OP_LANE, 64'hfff0000000000000, 64'h0, SH | DB | 14'h3, 64'hfff0, M_A, 4'h0);
        chk(OP_LANE, 64'hfff0000000000000, 64'h0, SH | DB | AS | 14'h3, 64'hfffffffffffffff0,
            M_A, 4'h0);
        chk(OP_LANE, 64'h1, 64'h0, SH | 14'h2, 64'h0, M_A, 4'h1);
        chk(OP_LANE, 64'h1, 64'h0, DB | 14'h8, 64'h0, M_A, 4'h1);
        $display("test lane done");
    endtask

    // mid-run reset must clear results left standing and the write-back copy
    task automatic t_reset();
        @(posedge clk_i);
        #1;
        rst_n_i = 1'b0;
        #1;
        `CHK({vld_o, res_o, cls_o, flg_o, res_ext_o}, 73'h0)
        `CHK(rf_reg, 64'h0)
        @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        chk(OP_NANCHK, 64'h3f800000, 64'h0, 14'h0, 64'h3f800000, M_L, 4'h0);
        $display("test reset done");
    endtask

    // reset for three cycles, released off the edge, then the scenarios
    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        `CHK({vld_o, res_o, cls_o, flg_o}, 72'h0)
        rst_n_i = 1'b1;
        t_class();
        t_nan();
        t_pack();
        t_fmul();
        t_lane();
        t_reset();
        close_out();
    end
endmodule
